// *** inc/lcfm_pkg.sv ***
// Constants, register map and timing for the LED channel fault monitor.
package lcfm_pkg;

  // ==========================================================================
  // Widths
  localparam int NCH    = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int TEMP_W = 8;
  localparam int QCNT_W = 20;
  localparam int SCL_W  = 10;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CFG  = 8'h01;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h07;
  localparam logic [ADDR_W-1:0] REG_DLY  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_REN  = 8'h0a;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] CFG_RST = 8'h01;
  localparam logic [DATA_W-1:0] DLY_RST = 8'h00;
  localparam logic [DATA_W-1:0] REN_RST = 8'h7f;

  // ==========================================================================
  // Field positions
  localparam int CFG_TEN_BIT  = 0;
  localparam int DLY_DEL_LSB  = 0;
  localparam int DLY_DEL_W    = 3;
  localparam int DLY_LVL_LSB  = 4;
  localparam int DLY_LVL_W    = 2;
  localparam int OPEN_LSB     = 0;
  localparam int SHORT_LSB    = 3;
  localparam int TSD_BIT      = 6;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int SHORT_QUAL_US   = 5000;
  localparam int SHORT_QUAL_CYC  = (CLK_HZ / 1_000_000) * SHORT_QUAL_US;
  localparam int OPEN_UNIT_US    = 1000;
  localparam int OPEN_UNIT_CYC   = (CLK_HZ / 1_000_000) * OPEN_UNIT_US;

  // ==========================================================================
  // Thermal figures, temperatures in degrees C, scale in 0.1 percent steps
  localparam logic [15:0] T_ROLL      = 16'h0091;
  localparam logic [15:0] T_SHDN      = 16'h00af;
  localparam logic [15:0] T_RECOV     = 16'h0091;
  localparam logic [15:0] ROLL_SLOPE  = 16'h0026;
  localparam logic [15:0] SCALE_FULL  = 16'h03e8;
  localparam logic [15:0] SCALE_FLOOR = 16'h0032;

endpackage

// *** design/lcfm_qual.sv ***
// Continuous-condition qualifier: flag rises after the condition holds a full limit.
module lcfm_qual
  import lcfm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire logic              cond,
  input  wire logic [QCNT_W-1:0] limit,
  output logic                   flag
);

  // ==========================================================================
  // Counter
  logic [QCNT_W-1:0] cnt_r;
  logic [QCNT_W-1:0] cnt_nxt;
  logic              flag_nxt;
  wire               live    = enable && cond;
  wire               reached = (cnt_r >= (limit - QCNT_W'(1)));

  // Any gap in the condition restarts the count, so glitches never qualify.
  assign cnt_nxt  = !live ? '0 : (reached ? cnt_r : cnt_r + QCNT_W'(1));
  assign flag_nxt = live && (flag || reached);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      flag  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      flag  <= flag_nxt;
    end
  end

endmodule

// *** design/lcfm_top.sv ***
// Fault supervision for three LED current channels: open, short, rolloff, shutdown.
//
// Contract
// - Open detection waits for selected supply level.
// - Open fault needs continuous low headroom delay.
// - Open fault: keep sourcing, set flag, pull low.
// - Open removed: flag clears, output released automatically.
// - Short fault needs output low for qualify time.
// - Short: reduce current, set flag, pull low.
// - Short removed: restore current, clear flag, release.
// - Fault output is open drain, low when reporting.
// - Open and short detection individually disableable.
// - Open fault reporting postponed by delay field.
// - Above rolloff temperature current falls, then off.
// - Rolloff disableable by configuration bit.
// - Overtemperature: channels off, flag set, pull low.
// - Restart blocked until cooled below recovery.
// - Restart clears shutdown flag, releases output.
// - Shutdown reporting suppressible by enable bit.
module lcfm_top
  import lcfm_pkg::*;
#(
  parameter int SHORT_QUAL_CYC_P = SHORT_QUAL_CYC,
  parameter int OPEN_UNIT_CYC_P  = OPEN_UNIT_CYC
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [NCH-1:0]    chan_req,
  input  wire logic [NCH-1:0]    open_cmp,
  input  wire logic [NCH-1:0]    short_cmp,
  input  wire logic [3:0]        supply_above,
  input  wire logic [TEMP_W-1:0] temp_c,
  output logic      [NCH-1:0]    chan_on,
  output logic      [NCH-1:0]    chan_reduced,
  output logic      [SCL_W-1:0]  current_scale,
  output logic                   fault_indicator_n_out,
  output logic                   fault_indicator_n_oe
);

  // ==========================================================================
  // Register file
  logic [DATA_W-1:0] cfg_r;
  logic [DATA_W-1:0] dly_r;
  logic [DATA_W-1:0] ren_r;
  wire               wr_cfg = reg_wr && (reg_addr == REG_CFG);
  wire               wr_dly = reg_wr && (reg_addr == REG_DLY);
  wire               wr_ren = reg_wr && (reg_addr == REG_REN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RST;
      dly_r <= DLY_RST;
      ren_r <= REN_RST;
    end else begin
      if (wr_cfg) begin
        cfg_r <= reg_wdata;
      end
      if (wr_dly) begin
        dly_r <= reg_wdata;
      end
      if (wr_ren) begin
        ren_r <= reg_wdata;
      end
    end
  end

  wire                 thermal_rolloff_enable         = cfg_r[CFG_TEN_BIT];
  wire [DLY_DEL_W-1:0] delay_field                    = dly_r[DLY_DEL_LSB +: DLY_DEL_W];
  wire [DLY_LVL_W-1:0] open_detect_supply_level       = dly_r[DLY_LVL_LSB +: DLY_LVL_W];
  wire [NCH-1:0]       open_en                        = ren_r[OPEN_LSB +: NCH];
  wire [NCH-1:0]       short_en                       = ren_r[SHORT_LSB +: NCH];
  wire                 thermal_shutdown_report_enable = ren_r[TSD_BIT];

  // ==========================================================================
  // Open and short qualification
  // Open detection is held off during supply sag so a brownout is not reported as a string fault.
  wire              supply_ok = supply_above[open_detect_supply_level];
  wire [QCNT_W-1:0] open_limit;
  wire [QCNT_W-1:0] short_limit = QCNT_W'(SHORT_QUAL_CYC_P);
  wire [NCH-1:0]    open_flag;
  wire [NCH-1:0]    short_flag;

  assign open_limit = QCNT_W'(({17'h00000, delay_field} + 20'h00001)
                      * QCNT_W'(OPEN_UNIT_CYC_P));

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      lcfm_qual u_open (
        .clk    (clk),
        .rst_n  (rst_n),
        .enable (supply_ok && open_en[gi] && chan_on[gi]),
        .cond   (open_cmp[gi]),
        .limit  (open_limit),
        .flag   (open_flag[gi])
      );
      lcfm_qual u_short (
        .clk    (clk),
        .rst_n  (rst_n),
        .enable (short_en[gi] && chan_on[gi]),
        .cond   (short_cmp[gi]),
        .limit  (short_limit),
        .flag   (short_flag[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Thermal rolloff
  wire [15:0] temp_w     = {8'h00, temp_c};
  wire        roll_hot   = thermal_rolloff_enable && (temp_w > T_ROLL);
  wire [15:0] roll_delta = temp_w - T_ROLL;
  wire [15:0] roll_drop  = roll_delta * ROLL_SLOPE;
  wire        roll_cut   = roll_hot && (roll_drop > (SCALE_FULL - SCALE_FLOOR));
  wire [15:0] scale_w    = !roll_hot ? SCALE_FULL :
                           (roll_cut ? 16'h0000 : SCALE_FULL - roll_drop);

  // ==========================================================================
  // Thermal shutdown and restart lockout
  logic           tsd_r;
  logic [NCH-1:0] req_prev_r;
  wire            over_temp = temp_w > T_SHDN;
  wire            cooled    = temp_w < T_RECOV;
  wire [NCH-1:0]  req_rise  = chan_req & ~req_prev_r;
  // Only a fresh turn-on request after cooling restarts; a held level cannot.
  wire            restart   = tsd_r && cooled && (req_rise != '0);
  // Setting wins over the restart clear when both land together.
  wire            tsd_nxt   = over_temp || (tsd_r && !restart);
  wire            off_all   = tsd_nxt || roll_cut;
  wire [NCH-1:0]  on_nxt    = chan_req & ~{NCH{off_all}};

  // ==========================================================================
  // Fault output
  wire tsd_rep  = tsd_r && thermal_shutdown_report_enable;
  wire fault_w  = (open_flag != '0) || (short_flag != '0) || tsd_rep;
  wire [DATA_W-1:0] stat_w = {1'b0, tsd_r, short_flag, open_flag};
  wire [DATA_W-1:0] rd_w   = (reg_addr == REG_CFG)  ? cfg_r  :
                             (reg_addr == REG_STAT) ? stat_w :
                             (reg_addr == REG_DLY)  ? dly_r  :
                             (reg_addr == REG_REN)  ? ren_r  : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tsd_r                 <= 1'b0;
      req_prev_r            <= '0;
      chan_on               <= '0;
      chan_reduced          <= '0;
      current_scale         <= SCL_W'(SCALE_FULL);
      fault_indicator_n_out <= 1'b0;
      fault_indicator_n_oe  <= 1'b0;
      reg_rdata             <= '0;
    end else begin
      tsd_r                 <= tsd_nxt;
      req_prev_r            <= chan_req;
      chan_on               <= on_nxt;
      chan_reduced          <= short_flag;
      current_scale         <= SCL_W'(scale_w);
      fault_indicator_n_out <= 1'b0;
      fault_indicator_n_oe  <= fault_w;
      if (reg_rd) begin
        reg_rdata <= rd_w;
      end
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence cooled_restart_s;
    tsd_r && cooled && !over_temp && (req_rise != '0);
  endsequence

  sequence released_s;
    !tsd_r ##0 (tsd_r == 1'b0);
  endsequence

  supply_gate_a: assert property (!supply_ok |=> open_flag == '0)
    else $error("open flag set while supply below open detect level");
  open_hold_a: assert property ($rose(open_flag[0]) |->
                                $past(open_cmp[0], 1) && $past(open_cmp[0], 2))
    else $error("open flag rose without a held condition");
  open_report_a: assert property ($rose(open_flag[0]) |=> fault_indicator_n_oe
                                  ##0 chan_on[0] == $past(on_nxt[0]))
    else $error("open fault not reported on fault output");
  open_clear_a: assert property (open_flag[0] && !open_cmp[0] |=> !open_flag[0])
    else $error("open flag stuck after condition removed");
  short_hold_a: assert property ($rose(short_flag[1]) |->
                                 $past(short_cmp[1], 1) && $past(short_cmp[1], 2))
    else $error("short flag rose without a held condition");
  short_cut_a: assert property ($rose(short_flag[0]) |=>
                                chan_reduced[0] && fault_indicator_n_oe)
    else $error("short did not reduce current and report");
  short_restore_a: assert property ($fell(short_flag[0]) |=> !chan_reduced[0])
    else $error("current not restored after short removed");
  fault_idle_a: assert property (!fault_w |=> !fault_indicator_n_oe && !fault_indicator_n_out)
    else $error("fault output driven with no reported fault");
  open_disable_a: assert property (!open_en[2] |=> !open_flag[2])
    else $error("disabled open detection still flagged");
  short_disable_a: assert property (!short_en[1] |=> !short_flag[1])
    else $error("disabled short detection still flagged");
  tsd_restart_a: assert property (restart && !over_temp && !roll_cut
                                  |=> chan_on == $past(chan_req))
    else $error("channels not restarted after cooling");
  roll_off_a: assert property (roll_cut |=> chan_on == '0 && current_scale == '0)
    else $error("channels not off below rolloff floor");
  roll_disable_a: assert property (!thermal_rolloff_enable && !over_temp && !tsd_r
                                   |=> current_scale == SCL_W'(SCALE_FULL))
    else $error("rolloff acted while disabled");
  tsd_enter_a: assert property (over_temp |=> tsd_r && chan_on == '0)
    else $error("shutdown did not turn channels off");
  tsd_lock_a: assert property (tsd_r && !cooled |=> tsd_r ##0 chan_on == '0)
    else $error("restart allowed before cooling");
  tsd_release_a: assert property (cooled_restart_s |=> released_s)
    else $error("shutdown flag not cleared on restart");
  tsd_mask_a: assert property (tsd_r && !thermal_shutdown_report_enable && open_flag == '0
                               && short_flag == '0 |=> !fault_indicator_n_oe)
    else $error("shutdown reported while its reporting is disabled");

endmodule

// *** dv/lcfm_led_model.sv ***
// Behavioural model of the three LED strings as seen through their comparators.
module lcfm_led_model
  import lcfm_pkg::*;
(
  input  wire logic [NCH-1:0] chan_on,
  input  wire logic [NCH-1:0] open_fault,
  input  wire logic [NCH-1:0] short_fault,
  output logic      [NCH-1:0] open_cmp,
  output logic      [NCH-1:0] short_cmp
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Comparators
  // A broken string only loses headroom while its source tries to drive it.
  assign open_cmp  = open_fault & chan_on;
  // A hard short pulls the output low whether or not the source is on.
  assign short_cmp = short_fault;
endmodule

// *** dv/lcfm_top_tb.sv ***
// Self-checking testbench of the LED channel fault monitor.
module lcfm_top_tb;
  import lcfm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [NCH-1:0]    chan_req;
  logic [NCH-1:0]    open_cmp;
  logic [NCH-1:0]    short_cmp;
  logic [NCH-1:0]    open_fault;
  logic [NCH-1:0]    short_fault;
  logic [3:0]        supply_above;
  logic [TEMP_W-1:0] temp_c;
  logic [NCH-1:0]    chan_on;
  logic [NCH-1:0]    chan_reduced;
  logic [SCL_W-1:0]  current_scale;
  logic              fault_out;
  logic              fault_oe;
  int                err_total;
  int                comparisons;
  logic [DATA_W-1:0] rd_v;

  // Short counts keep the qualification windows to a few cycles.
  lcfm_top #(.SHORT_QUAL_CYC_P(8), .OPEN_UNIT_CYC_P(4)) dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_req(chan_req),
    .open_cmp(open_cmp), .short_cmp(short_cmp), .supply_above(supply_above),
    .temp_c(temp_c), .chan_on(chan_on), .chan_reduced(chan_reduced),
    .current_scale(current_scale), .fault_indicator_n_out(fault_out),
    .fault_indicator_n_oe(fault_oe));

  lcfm_led_model strings (
    .chan_on(chan_on), .open_fault(open_fault), .short_fault(short_fault),
    .open_cmp(open_cmp), .short_cmp(short_cmp));

  // ==========================================================================
  // Tasks
  task automatic end_sim();
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rd_v);
    chk({8'h00, rd_v}, {8'h00, exp});
  endtask

  // The open-drain pin is only ever pulled low, so its data stays 0.
  task automatic wait_oe(input logic v, input int n);
    int i;
    for (i = 0; i < n && fault_oe !== v; i++) cyc(1);
    if (fault_oe !== v) begin
      err_total++;
      end_sim();
    end
    chk({15'h0, fault_out}, 16'h0000);
  endtask

  task automatic retoggle(input logic [7:0] t);
    @(posedge clk);
    temp_c <= t;
    chan_req <= 3'h0;
    cyc(2);
    chan_req <= 3'h7;
    cyc(3);
  endtask

  // ==========================================================================
  // Clock and stimulus
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    err_total = 0; comparisons = 0; rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0; chan_req = 3'h7; open_fault = 3'h0; short_fault = 3'h0;
    supply_above = 4'h0; temp_c = 8'h19;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    rdchk(REG_CFG, CFG_RST);
    rdchk(REG_DLY, DLY_RST);
    rdchk(REG_REN, REN_RST);
    rdchk(REG_STAT, 8'h00);
    wr(REG_STAT, 8'hff);
    rdchk(REG_STAT, 8'h00);
    rdchk(8'h03, 8'h00);
    // Open fault with delay code 2: qualification is 12 cycles.
    wr(REG_DLY, 8'h02);
    open_fault <= 3'h1;
    cyc(30);
    chk({15'h0, fault_oe}, 16'h0000);
    supply_above <= 4'h1;
    cyc(10);
    chk({15'h0, fault_oe}, 16'h0000);
    wait_oe(1'b1, 8);
    chk({13'h0, chan_on}, 16'h0007);
    rdchk(REG_STAT, 8'h01);
    open_fault <= 3'h0;
    wait_oe(1'b0, 4);
    rdchk(REG_STAT, 8'h00);
    // Short on channel 1, with an open on channel 2 overlapping it.
    short_fault <= 3'h2;
    cyc(5);
    chk({15'h0, fault_oe}, 16'h0000);
    wait_oe(1'b1, 8);
    chk({13'h0, chan_reduced}, 16'h0002);
    rdchk(REG_STAT, 8'h10);
    open_fault <= 3'h4;
    cyc(20);
    short_fault <= 3'h0;
    cyc(4);
    chk({15'h0, fault_oe}, 16'h0001);
    open_fault <= 3'h0;
    wait_oe(1'b0, 4);
    chk({13'h0, chan_reduced}, 16'h0000);
    rdchk(REG_STAT, 8'h00);
    // Short detection of channel 1 switched off.
    wr(REG_REN, 8'h6f);
    short_fault <= 3'h2;
    cyc(20);
    chk({15'h0, fault_oe}, 16'h0000);
    chk({13'h0, chan_reduced}, 16'h0000);
    short_fault <= 3'h0;
    wr(REG_REN, 8'h7f);
    // Thermal rolloff, then shutdown and the restart lockout.
    temp_c <= 8'h96;
    cyc(4);
    chk({6'h0, current_scale}, 16'd810);
    temp_c <= 8'hab;
    cyc(3);
    chk({6'h0, current_scale}, 16'd0);
    chk({13'h0, chan_on}, 16'h0000);
    wr(REG_CFG, 8'h00);
    cyc(3);
    chk({6'h0, current_scale}, 16'd1000);
    chk({13'h0, chan_on}, 16'h0007);
    temp_c <= 8'hb0;
    wait_oe(1'b1, 4);
    chk({13'h0, chan_on}, 16'h0000);
    rdchk(REG_STAT, 8'h40);
    retoggle(8'h96);
    chk({13'h0, chan_on}, 16'h0000);
    retoggle(8'h8c);
    chk({13'h0, chan_on}, 16'h0007);
    chk({15'h0, fault_oe}, 16'h0000);
    rdchk(REG_STAT, 8'h00);
    wr(REG_REN, 8'h3f);
    temp_c <= 8'hb0;
    cyc(4);
    chk({15'h0, fault_oe}, 16'h0000);
    rdchk(REG_STAT, 8'h40);
    end_sim();
  end
endmodule
